// ==== inc/sfc_regs.svh ====
`ifndef SFC_REGS_SVH
`define SFC_REGS_SVH
`define SFC_OP_WRITE_ENABLE_CMD      8'h06
`define SFC_OP_WRDI      8'h04
`define SFC_OP_READ      8'h03
`define SFC_OP_READ4     8'h13
`define SFC_OP_PP        8'h02
`define SFC_OP_PP4       8'h12
`define SFC_OP_SE        8'h20
`define SFC_OP_SE4       8'h21
`define SFC_OP_CE        8'hc7
`define SFC_OP_ENOTP     8'hb1
`define SFC_OP_EXOTP     8'hc1
`define SFC_OP_RDSEC     8'h2b
`define SFC_OP_WRSEC     8'h2f
`define SFC_OP_EN4       8'hb7
`define SFC_OP_EX4       8'he9
`define SFC_OP_WRSEG     8'hc5
`define SFC_OP_RDSEG     8'hc8
`define SFC_OP_ENTER_QUAD_CMD      8'h35
`define SFC_OP_EXIT_QUAD_CMD    8'hf5
`define SFC_SEG_RESET    8'h00
`define SFC_SEC_FLOCK    0
`define SFC_SEC_CLOCK    1
`define SFC_OTP_HALF_BIT 9
`define SFC_BLK_LSB      16
`define SFC_ALL_LEVEL    4'ha
`define SFC_BUSY_NS      1000
`define SFC_CLK_NS       25
`define SFC_BUSY_CYC     ((`SFC_BUSY_NS + `SFC_CLK_NS - 1) / `SFC_CLK_NS)
`endif

// ==== inc/sfc_pkg.sv ====
package sfc_pkg;
  typedef enum logic [2:0] {
    SFC_IDLE  = 3'h0,
    SFC_OPC   = 3'h1,
    SFC_ADDR  = 3'h3,
    SFC_DATA  = 3'h2,
    SFC_OUT   = 3'h6,
    SFC_STBY  = 3'h7
  } sfc_state_type;
endpackage

// ==== design/sfc_cmd_front.sv ====
`include "sfc_regs.svh"
`default_nettype none
// Behaviour
// (R1) Bottom protection: level n protects 2^(n-1) blocks.
// (R2) Security bit 0 reports factory OTP lock.
// (R3) Host programs OTP inside enter/exit OTP mode.
// (R4) Security write with bit 1 locks customer half.
// (R5) Locked OTP range refuses any change.
// (R6) OTP mode blocks main array access.
// (R7) OTP 000-1FF customer, 200-3FF factory.
// (R8) Invalid command: standby, output off till select.
// (R9) Valid command stays active until select rises.
// (R10) Sample on rising edge, shift on falling.
// (R11) Reads may end after any output bit.
// (R12) Write-type commands need byte-aligned deselect.
// (R13) Busy device ignores array access.
// (R14) Wide mode commands set/clear wide address flag.
// (R15) Wide mode ignores segment register.
// (R16) Four-byte opcodes always take 32-bit address.
// (R17) Segment register 8-bit, bit 0 is A24.
// (R18) Three-byte accesses stay inside selected segment.
// (R19) Continuous read wraps to next segment.
// (R20) Chip erase whole; others confined to segment.
// (R21) Opcode 35h enters four-line command mode.
// (R22) Opcode F5h returns to single-line mode.
// (R23) Protection block is 64 kilobytes.
// (R24) Data change requires write enable latch.
// (R25) Program/erase into protected block ignored.
module sfc_cmd_front (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        sclk,
  input  wire logic        chipSelectN,
  input  wire logic [3:0]  sioIn,
  output logic      [3:0]  sioOut,
  output logic      [3:0]  sioOe,
  input  wire logic [3:0]  protectLevelBits,
  input  wire logic        protectFromBottom,
  input  wire logic        factoryOtpLocked,
  input  wire logic        arrayBusy,
  input  wire logic [7:0]  arrayRdData,
  output logic             cmdStb,
  output logic      [7:0]  cmdOp,
  output logic      [31:0] cmdAddr,
  output logic             cmdOtp,
  output logic             wideAddrFlag,
  output logic             quadMode,
  output logic             writeEnableLatch
);
  // Link side, clocked by sclk. Frames are bounded by chipSelectN.
  logic [7:0]  shIn_ff, nxt_shIn;
  logic [2:0]  bitCnt_ff, nxt_bitCnt;
  logic [2:0]  byteCnt_ff, nxt_byteCnt;
  logic [7:0]  op_ff, nxt_op;
  logic [31:0] addr_ff, nxt_addr;
  logic [7:0]  dat_ff, nxt_dat;
  sfc_pkg::sfc_state_type st_ff, nxt_st;

  function automatic logic isFour(input logic [7:0] op);
    isFour = (op == `SFC_OP_READ4) || (op == `SFC_OP_PP4) ||
             (op == `SFC_OP_SE4);
  endfunction
  function automatic logic hasAddr(input logic [7:0] op);
    hasAddr = isFour(op) || (op == `SFC_OP_READ) ||
              (op == `SFC_OP_PP) || (op == `SFC_OP_SE);
  endfunction
  function automatic logic isKnown(input logic [7:0] op);
    isKnown = hasAddr(op) ||
      (op inside {`SFC_OP_WRITE_ENABLE_CMD, `SFC_OP_WRDI, `SFC_OP_CE,
                  `SFC_OP_ENOTP, `SFC_OP_EXOTP, `SFC_OP_RDSEC,
                  `SFC_OP_WRSEC, `SFC_OP_EN4, `SFC_OP_EX4,
                  `SFC_OP_WRSEG, `SFC_OP_RDSEG, `SFC_OP_ENTER_QUAD_CMD,
                  `SFC_OP_EXIT_QUAD_CMD});
  endfunction

  // Mode flags change only between frames while sclk stands still;
  // quad mode is read as a steady level, the wide flag via two flops.
  logic wideL1_ff, wideL2_ff;
  logic [2:0] addrBytes;
  logic [7:0] shNext;
  logic       byteDone;

  always_comb
  begin
    addrBytes = (isFour(op_ff) || wideL2_ff) ? 3'h4 : 3'h3; // [R14] [R16]
    shNext = quadMode ? {shIn_ff[3:0], sioIn} :
                        {shIn_ff[6:0], sioIn[0]}; // [R21]
    byteDone = quadMode ? (bitCnt_ff == 3'h1) : (bitCnt_ff == 3'h7);
    nxt_shIn = shNext;
    nxt_bitCnt = byteDone ? 3'h0 : bitCnt_ff + 3'h1;
    nxt_byteCnt = byteCnt_ff;
    nxt_op = op_ff;
    nxt_addr = addr_ff;
    nxt_dat = dat_ff;
    nxt_st = st_ff;
    if (byteDone)
    begin
      unique case (st_ff)
        sfc_pkg::SFC_IDLE, sfc_pkg::SFC_OPC:
        begin
          nxt_op = shNext;
          nxt_byteCnt = 3'h0;
          nxt_addr = 32'h0;
          if (!isKnown(shNext))
            nxt_st = sfc_pkg::SFC_STBY; // [R8]
          else if (hasAddr(shNext))
            nxt_st = sfc_pkg::SFC_ADDR; // [R9]
          else
            nxt_st = sfc_pkg::SFC_DATA;
        end
        sfc_pkg::SFC_ADDR:
        begin
          nxt_addr = {addr_ff[23:0], shNext};
          nxt_byteCnt = byteCnt_ff + 3'h1;
          if (byteCnt_ff + 3'h1 == addrBytes)
            nxt_st = sfc_pkg::SFC_DATA;
        end
        sfc_pkg::SFC_DATA:
          nxt_dat = shNext;
        default:
          nxt_st = st_ff;
      endcase
    end
  end

  // Link shifter, counters and state clear while select is high; the system side learns of
  // the frame end through its own synchroniser.
  always_ff @(posedge sclk or posedge chipSelectN) // [R10]
  begin
    if (chipSelectN)
    begin
      shIn_ff <= 8'h00;
      bitCnt_ff <= 3'h0;
      byteCnt_ff <= 3'h0;
      st_ff <= sfc_pkg::SFC_IDLE;
    end
    else
    begin
      shIn_ff <= nxt_shIn;
      bitCnt_ff <= nxt_bitCnt;
      byteCnt_ff <= nxt_byteCnt;
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge sclk)
  begin
    op_ff <= nxt_op;
    addr_ff <= nxt_addr;
    dat_ff <= nxt_dat;
    wideL1_ff <= wideAddrFlag;
    wideL2_ff <= wideL1_ff;
  end

  // Frame summary snapshot, taken in the system domain just before select is
  // seen high; bit count and state clear with select, so they pass the same two-flop delay.
  logic [3:0] csSync_ff;
  logic [2:0] bcSync1_ff, bcSync2_ff;
  logic [2:0] stSync1_ff, stSync2_ff;
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      csSync_ff <= 4'hf;
    else
      csSync_ff <= {csSync_ff[2:0], chipSelectN};
    bcSync1_ff <= bitCnt_ff;
    bcSync2_ff <= bcSync1_ff;
    stSync1_ff <= 3'(st_ff);
    stSync2_ff <= stSync1_ff;
  end

  // Opcode, address and data stand still once select is high; they are
  // taken one cycle before the frame is acted on, never during it.
  logic [7:0]  lOp_ff, nxt_lOp;
  logic [31:0] lAddr_ff, nxt_lAddr;
  logic [7:0]  lDat_ff, nxt_lDat;
  logic        lAligned_ff, nxt_lAligned;
  logic [2:0]  lSt_ff, nxt_lSt;
  logic        csRise;
  always_comb
  begin
    csRise = csSync_ff[2] && !csSync_ff[3];
    nxt_lOp = op_ff;
    nxt_lAddr = addr_ff;
    nxt_lDat = dat_ff;
    nxt_lAligned = (bcSync2_ff == 3'h0); // [R12]
    nxt_lSt = stSync2_ff;
    if (!csSync_ff[1])
    begin
      nxt_lOp = lOp_ff;
      nxt_lAddr = lAddr_ff;
      nxt_lDat = lDat_ff;
    end
  end
  always_ff @(posedge clk_sys)
  begin
    lOp_ff <= nxt_lOp;
    lAddr_ff <= nxt_lAddr;
    lDat_ff <= nxt_lDat;
    if (!csSync_ff[1])
    begin
      lAligned_ff <= nxt_lAligned;
      lSt_ff <= nxt_lSt;
    end
  end

  // System side command execution.
  logic [7:0]  seg_ff, nxt_seg;
  logic [1:0]  sec_ff, nxt_sec;
  logic        otp_ff, nxt_otp;
  logic        wide_ff, nxt_wide;
  logic        quad_ff, nxt_quad;
  logic        wel_ff, nxt_wel;
  logic        stb_ff, nxt_stb;
  logic [7:0]  cOp_ff, nxt_cOp;
  logic [31:0] cAddr_ff, nxt_cAddr;
  logic [8:0]  blk;
  logic        prot;
  logic        isWrite;
  logic        isArray;

  always_comb
  begin
    nxt_seg = seg_ff;
    nxt_sec = {sec_ff[`SFC_SEC_CLOCK], factoryOtpLocked}; // [R2]
    nxt_otp = otp_ff;
    nxt_wide = wide_ff;
    nxt_quad = quad_ff;
    nxt_wel = wel_ff;
    nxt_stb = 1'b0;
    nxt_cOp = cOp_ff;
    nxt_cAddr = cAddr_ff;
    // Address: wide or four-byte opcodes use 32 bits, else segment.
    if (isFour(lOp_ff) || wide_ff) // [R15] [R16]
      nxt_cAddr = lAddr_ff;
    else
      nxt_cAddr = {7'h00, seg_ff[0], lAddr_ff[23:0]}; // [R17] [R18] [R20]
    blk = nxt_cAddr[`SFC_BLK_LSB +: 9]; // [R23]
    if (protectLevelBits == 4'h0)
      prot = 1'b0;
    else if (protectLevelBits >= `SFC_ALL_LEVEL)
      prot = 1'b1;
    else if (protectFromBottom) // [R1]
      prot = (10'(blk) < (10'h1 << (protectLevelBits - 4'h1)));
    else
      prot = (10'(blk) >= (10'h200 - (10'h1 << (protectLevelBits - 4'h1))));
    isWrite = lOp_ff inside {`SFC_OP_PP, `SFC_OP_PP4, `SFC_OP_SE,
                             `SFC_OP_SE4, `SFC_OP_CE};
    isArray = isWrite || lOp_ff inside {`SFC_OP_READ, `SFC_OP_READ4};
    if (csRise && lSt_ff == 3'(sfc_pkg::SFC_DATA)) // [R8] [R9]
    begin
      if (lOp_ff == `SFC_OP_WRITE_ENABLE_CMD && lAligned_ff)
        nxt_wel = 1'b1;
      else if (lOp_ff == `SFC_OP_WRDI && lAligned_ff)
        nxt_wel = 1'b0;
      else if (!lAligned_ff && !(lOp_ff inside {`SFC_OP_READ,
               `SFC_OP_READ4, `SFC_OP_RDSEC, `SFC_OP_RDSEG}))
        nxt_wel = wel_ff; // [R12] [R11]
      else if (lOp_ff inside {`SFC_OP_EN4, `SFC_OP_EX4})
        nxt_wide = (lOp_ff == `SFC_OP_EN4); // [R14]
      else if (lOp_ff inside {`SFC_OP_ENTER_QUAD_CMD, `SFC_OP_EXIT_QUAD_CMD})
        nxt_quad = (lOp_ff == `SFC_OP_ENTER_QUAD_CMD); // [R21] [R22]
      else if (lOp_ff inside {`SFC_OP_ENOTP, `SFC_OP_EXOTP})
        nxt_otp = (lOp_ff == `SFC_OP_ENOTP); // [R3]
      else if (lOp_ff == `SFC_OP_WRSEG && wel_ff)
      begin
        nxt_seg = {7'h00, lDat_ff[0]}; // [R17]
        nxt_wel = 1'b0;
      end
      else if (lOp_ff == `SFC_OP_WRSEC && wel_ff)
      begin
        if (lDat_ff[`SFC_SEC_CLOCK])
          nxt_sec[`SFC_SEC_CLOCK] = 1'b1; // [R4]
        nxt_wel = 1'b0;
      end
      else if (isArray && !arrayBusy) // [R13]
      begin
        if (otp_ff)
        begin
          // Main array unreachable in OTP mode; only reads and
          // programs into an unlocked half reach the OTP area.
          if (!isWrite || (wel_ff && lOp_ff inside {`SFC_OP_PP,
              `SFC_OP_PP4} && !(lAddr_ff[`SFC_OTP_HALF_BIT] ?
              sec_ff[`SFC_SEC_FLOCK] : sec_ff[`SFC_SEC_CLOCK])))
          begin // [R6] [R5] [R7] [R3]
            nxt_stb = 1'b1;
            nxt_cAddr = {22'h0, lAddr_ff[9:0]};
          end
          if (isWrite)
            nxt_wel = 1'b0;
        end
        else
        begin
          nxt_stb = !isWrite || (wel_ff && (lOp_ff == `SFC_OP_CE ?
                    protectLevelBits == 4'h0 : !prot)); // [R24] [R25] [R20]
          nxt_wel = isWrite ? 1'b0 : wel_ff;
        end
      end
      nxt_cOp = lOp_ff;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      seg_ff <= `SFC_SEG_RESET;
      sec_ff <= 2'h0;
      otp_ff <= 1'b0;
      wide_ff <= 1'b0;
      quad_ff <= 1'b0;
      wel_ff <= 1'b0;
      stb_ff <= 1'b0;
      cOp_ff <= 8'h00;
      cAddr_ff <= 32'h0;
    end
    else
    begin
      seg_ff <= nxt_seg;
      sec_ff <= nxt_sec;
      otp_ff <= nxt_otp;
      wide_ff <= nxt_wide;
      quad_ff <= nxt_quad;
      wel_ff <= nxt_wel;
      stb_ff <= nxt_stb;
      cOp_ff <= nxt_cOp;
      cAddr_ff <= nxt_cAddr;
    end
  end

  // Falling-edge output shifter. Segment wrap on long reads is left to
  // the array port, so the segment register is never touched here.
  logic [7:0] outSh_ff;
  logic       oe_ff;
  always_ff @(negedge sclk or posedge chipSelectN) // [R10] [R19]
  begin
    if (chipSelectN)
    begin
      outSh_ff <= 8'h00;
      oe_ff <= 1'b0; // [R11]
    end
    else
    begin
      oe_ff <= (st_ff == sfc_pkg::SFC_DATA) && !quadMode &&
               (op_ff inside {`SFC_OP_READ, `SFC_OP_READ4,
                `SFC_OP_RDSEC, `SFC_OP_RDSEG}); // [R8]
      if (bitCnt_ff == 3'h0)
        outSh_ff <= (op_ff == `SFC_OP_RDSEG) ? seg_ff :
                    (op_ff == `SFC_OP_RDSEC) ? {6'h00, sec_ff} :
                    arrayRdData;
      else
        outSh_ff <= {outSh_ff[6:0], 1'b0};
    end
  end

  always_comb
  begin
    sioOut = {2'h0, outSh_ff[7], 1'b0};
    sioOe = {2'h0, oe_ff, 1'b0};
    cmdStb = stb_ff;
    cmdOp = cOp_ff;
    cmdAddr = cAddr_ff;
    cmdOtp = otp_ff;
    wideAddrFlag = wide_ff;
    quadMode = quad_ff;
    writeEnableLatch = wel_ff;
  end
endmodule // sfc_cmd_front
`default_nettype wire

// ==== dv/sfc_cmd_front_monitor.sv ====
`include "sfc_regs.svh"
`default_nettype none
module sfc_cmd_front_monitor (
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        chipSelectN,
  input wire logic [3:0]  sioOe,
  input wire logic [3:0]  protectLevelBits,
  input wire logic        protectFromBottom,
  input wire logic        factoryOtpLocked,
  input wire logic        arrayBusy,
  input wire logic        cmdStb,
  input wire logic [7:0]  cmdOp,
  input wire logic [31:0] cmdAddr,
  input wire logic        cmdOtp,
  input wire logic        wideAddrFlag,
  input wire logic        quadMode,
  input wire logic        writeEnableLatch
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic       isProg;
  logic [9:0] protBlks;
  assign isProg = cmdOp == `SFC_OP_PP || cmdOp == `SFC_OP_PP4;
  // Levels at or above the all-level cover 512 blocks, one past the top.
  assign protBlks = protectLevelBits == 4'h0 ? 10'h000 :
    protectLevelBits >= `SFC_ALL_LEVEL ? 10'h200 :
    10'h001 << (protectLevelBits - 4'h1);
  a_stb_one_cycle: assert property (cmdStb |=> !cmdStb)
    else $error("command strobe longer than one cycle");
  a_stb_deselected: assert property (
    cmdStb |-> chipSelectN && $past(chipSelectN))
    else $error("command strobe inside a frame");
  a_wel_deselected: assert property (
    $rose(writeEnableLatch) |-> chipSelectN)
    else $error("write latch set inside a frame");
  a_wide_deselected: assert property (
    !$stable(wideAddrFlag) |-> chipSelectN)
    else $error("wide flag changed inside a frame");
  a_oe_idle_off: assert property (
    chipSelectN && $past(chipSelectN) |-> sioOe == 4'h0)
    else $error("output driven while deselected");
  a_prot_refused: assert property (
    cmdStb && isProg && !cmdOtp && protectFromBottom
    |-> {1'b0, cmdAddr[24:16]} >= protBlks)
    else $error("program into protected block");
  a_busy_refused: assert property (cmdStb && isProg |-> !arrayBusy)
    else $error("program while array busy");
  a_otp_factory: assert property (
    cmdStb && cmdOtp && isProg && factoryOtpLocked
    |-> !cmdAddr[`SFC_OTP_HALF_BIT])
    else $error("program into locked factory half");
  c_otp_prog: cover property (cmdStb && cmdOtp);
  c_wide_on: cover property ($rose(wideAddrFlag));
  c_quad_on: cover property ($rose(quadMode));
endmodule // sfc_cmd_front_monitor
bind sfc_cmd_front sfc_cmd_front_monitor u_mon (
  .clk_sys(clk_sys), .srst(srst), .chipSelectN(chipSelectN),
  .sioOe(sioOe), .protectLevelBits(protectLevelBits),
  .protectFromBottom(protectFromBottom),
  .factoryOtpLocked(factoryOtpLocked), .arrayBusy(arrayBusy),
  .cmdStb(cmdStb), .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdOtp(cmdOtp),
  .wideAddrFlag(wideAddrFlag), .quadMode(quadMode),
  .writeEnableLatch(writeEnableLatch));
`default_nettype wire

// ==== dv/sfc_host.sv ====
`default_nettype none
module sfc_host (
  output var logic       sclk,
  output var logic       chipSelectN,
  output var logic [3:0] sioIn,
  input wire logic [3:0] sioOut,
  input wire logic [3:0] sioOe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rx;
  logic       oeSeen;
  // A short select pulse at start clears the link shifter, counters and state, which have no
  // reset of their own.
  initial
  begin
    sclk = 1'b0;
    chipSelectN = 1'b0;
    sioIn = 4'h0;
    #1 chipSelectN = 1'b1;
  end
  always @(posedge sclk)
  begin
    if (sioOe !== 4'h0)
      oeSeen <= 1'b1;
    if (sioOe[1] === 1'b1)
      rx <= {rx[6:0], sioOut[1]};
  end
  task automatic tick;
    #40 sclk = 1'b1;
    #40 sclk = 1'b0;
  endtask
  // Whole bytes MSB first, then extra bits to end off a byte boundary.
  task automatic xfer(input logic [7:0] q[$], input int extra,
                      input bit quad);
    logic [7:0] b;
    rx = 8'h00;
    oeSeen = 1'b0;
    #7;
    chipSelectN = 1'b0;
    foreach (q[i])
    begin
      b = q[i];
      repeat (quad ? 2 : 8)
      begin
        sioIn = quad ? b[7:4] : {~b[7], ~b[7], ~b[7], b[7]};
        b = quad ? b << 4 : b << 1;
        tick();
      end
    end
    repeat (extra)
    begin
      sioIn = ~sioIn;
      tick();
    end
    #40 chipSelectN = 1'b1;
    sioIn = ~sioIn;
    #200;
  endtask
endmodule // sfc_host
`default_nettype wire

// ==== dv/sfc_cmd_front_test.sv ====
`include "sfc_regs.svh"
`default_nettype none
module sfc_cmd_front_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys, srst, sclk, chipSelectN, protectFromBottom;
  logic        factoryOtpLocked, arrayBusy, cmdStb, cmdOtp, lastOtp;
  logic        wideAddrFlag, quadMode, writeEnableLatch;
  logic [3:0]  sioIn, sioOut, sioOe, protectLevelBits;
  logic [7:0]  arrayRdData, cmdOp;
  logic [31:0] cmdAddr, lastAddr;
  int          fails, checks, nStb;
  sfc_cmd_front DUT (.clk_sys, .srst, .sclk, .chipSelectN, .sioIn,
    .sioOut, .sioOe, .protectLevelBits, .protectFromBottom,
    .factoryOtpLocked, .arrayBusy, .arrayRdData, .cmdStb, .cmdOp,
    .cmdAddr, .cmdOtp, .wideAddrFlag, .quadMode, .writeEnableLatch);
  sfc_host host (.sclk, .chipSelectN, .sioIn, .sioOut, .sioOe);
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys)
    if (cmdStb === 1'b1)
    begin
      nStb <= nStb + 1;
      lastAddr <= cmdAddr;
      lastOtp <= cmdOtp;
    end
  task automatic summarize;
    if (fails == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] q[$], input int extra = 0,
                     input bit quad = 1'b0);
    nStb = 0;
    host.xfer(q, extra, quad);
  endtask
  task automatic prog(input logic [7:0] op, input logic [31:0] a,
                      input bit four);
    cmd('{`SFC_OP_WRITE_ENABLE_CMD});
    if (four)
      cmd('{op, a[31:24], a[23:16], a[15:8], a[7:0], 8'h3c});
    else
      cmd('{op, a[23:16], a[15:8], a[7:0], 8'h3c});
  endtask
  task automatic t_wel;
    chk({wideAddrFlag, quadMode, writeEnableLatch, cmdStb}, 32'h0);
    prog(`SFC_OP_PP, 32'h0, 1'b0);
    cmd('{`SFC_OP_WRDI});
    cmd('{`SFC_OP_PP, 8'h01, 8'h00, 8'h00, 8'h11});
    chk(nStb, 0);
    cmd('{`SFC_OP_WRITE_ENABLE_CMD}, 3);
    chk(writeEnableLatch, 1'b0);
    cmd('{`SFC_OP_WRITE_ENABLE_CMD});
    chk(writeEnableLatch, 1'b1);
  endtask
  task automatic t_read;
    @(negedge clk_sys);
    arrayRdData = 8'h5a;
    cmd('{`SFC_OP_WRDI});
    cmd('{`SFC_OP_READ, 8'h00, 8'h00, 8'h00}, 3);
    chk(host.rx[2:0], 3'b010);
    cmd('{`SFC_OP_WRITE_ENABLE_CMD});
    chk(writeEnableLatch, 1'b1);
    cmd('{`SFC_OP_READ, 8'h00, 8'h00, 8'h00}, 8);
    chk(host.rx, 8'h5a);
  endtask
  task automatic t_prot;
    int lv[6] = '{1, 1, 9, 9, 10, 0};
    int bk[6] = '{0, 1, 255, 256, 511, 0};
    int ok[6] = '{0, 1, 0, 1, 0, 1};
    for (int i = 0; i < 6; i++)
    begin
      @(negedge clk_sys);
      protectFromBottom = 1'b1;
      protectLevelBits = 4'(lv[i]);
      prog(`SFC_OP_PP4, 32'(bk[i]) << 16, 1'b1);
      chk(nStb, ok[i]);
      if (ok[i] == 1)
        chk(lastAddr, 32'(bk[i]) << 16);
    end
    cmd('{`SFC_OP_WRITE_ENABLE_CMD});
    cmd('{`SFC_OP_CE});
    chk(nStb, 1);
  endtask
  task automatic t_seg;
    prog(`SFC_OP_PP, 32'h00123456, 1'b0);
    chk(lastAddr, 32'h00123456);
    chk(cmdOp, {24'h0, `SFC_OP_PP});
    cmd('{`SFC_OP_WRITE_ENABLE_CMD});
    cmd('{`SFC_OP_WRSEG, 8'hff});
    cmd('{`SFC_OP_RDSEG}, 8);
    chk(host.rx, 8'h01);
    prog(`SFC_OP_PP, 32'h00123456, 1'b0);
    chk(lastAddr, 32'h01123456);
    cmd('{`SFC_OP_WRITE_ENABLE_CMD});
    cmd('{`SFC_OP_EN4});
    chk(wideAddrFlag, 1'b1);
    prog(`SFC_OP_PP, 32'h00abcdef, 1'b1);
    chk(lastAddr, 32'h00abcdef);
    cmd('{`SFC_OP_WRITE_ENABLE_CMD});
    cmd('{`SFC_OP_EX4});
    chk(wideAddrFlag, 1'b0);
    cmd('{`SFC_OP_WRITE_ENABLE_CMD});
    cmd('{`SFC_OP_WRSEG, 8'h00});
  endtask
  task automatic t_busy;
    @(negedge clk_sys);
    arrayBusy = 1'b1;
    prog(`SFC_OP_PP4, 32'h01000000, 1'b1);
    chk(nStb, 0);
    @(negedge clk_sys);
    arrayBusy = 1'b0;
  endtask
  task automatic t_otp;
    @(negedge clk_sys);
    factoryOtpLocked = 1'b1;
    cmd('{`SFC_OP_RDSEC}, 8);
    chk(host.rx[0], 1'b1);
    cmd('{`SFC_OP_ENOTP});
    prog(`SFC_OP_PP, 32'h200, 1'b0);
    chk(nStb, 0);
    prog(`SFC_OP_PP, 32'h010, 1'b0);
    chk({nStb[1:0], lastOtp}, 3'b011);
    cmd('{`SFC_OP_WRITE_ENABLE_CMD});
    cmd('{`SFC_OP_WRSEC, 8'h02});
    cmd('{`SFC_OP_RDSEC}, 8);
    chk(host.rx[1:0], 2'b11);
    prog(`SFC_OP_PP, 32'h010, 1'b0);
    chk(nStb, 0);
    cmd('{`SFC_OP_READ, 8'h00, 8'h00, 8'h10}, 8);
    chk(lastOtp, 1'b1);
    chk(lastAddr, 32'h010);
    cmd('{`SFC_OP_EXOTP});
    prog(`SFC_OP_PP, 32'h010, 1'b0);
    chk(lastOtp, 1'b0);
  endtask
  task automatic t_modes;
    cmd('{8'hff, 8'h00}, 8);
    chk(host.oeSeen, 1'b0);
    cmd('{`SFC_OP_ENTER_QUAD_CMD});
    chk(quadMode, 1'b1);
    cmd('{`SFC_OP_EXIT_QUAD_CMD}, 0, 1'b1);
    chk(quadMode, 1'b0);
  endtask
  initial
  begin
    {srst, protectFromBottom, factoryOtpLocked, arrayBusy} = 4'hf;
    {protectLevelBits, arrayRdData} = 12'h0;
    protectFromBottom = 1'b0;
    factoryOtpLocked = 1'b0;
    arrayBusy = 1'b0;
    repeat (12) @(negedge clk_sys);
    srst = 1'b0;
    @(negedge clk_sys);
    t_wel();
    t_read();
    t_prot();
    t_seg();
    t_busy();
    t_otp();
    t_modes();
    summarize();
  end
  // About sixty frames of a few microseconds each fit well inside this.
  initial
  begin
    #1ms;
    fails++;
    summarize();
  end
endmodule // sfc_cmd_front_test
`default_nettype wire
